/* rtl/seep_defines.vh */
// Constants for the two-wire serial memory target
`ifndef SEEP_DEFINES_VH
`define SEEP_DEFINES_VH
`define SEEP_DEV_CODE   4'hA
`define SEEP_MEM_BYTES  4096
`define SEEP_ADDR_W     12
`define SEEP_PAGE_BYTES 32
`define SEEP_OFS_W      5
`define SEEP_ERASED     8'hFF
`define SEEP_PROG_US    5000
`define SEEP_CLK_MHZ    20
`define SEEP_PROG_CYC   (`SEEP_PROG_US * `SEEP_CLK_MHZ)
`endif

/* rtl/seep_target.v */
// Two-wire serial memory target with page buffer and timed programming
`timescale 1ns/1ps
`default_nettype none
`include "seep_defines.vh"
module seep_target #(
  parameter integer PROG_CYCLES = `SEEP_PROG_CYC,
  parameter integer HAS_STRAPS  = 1
) (
  // Clock and reset
  input  wire       SYS_CLK_IN,
  input  wire       RSTN_IN,
  // Bus pins
  input  wire       SCL_IN,
  input  wire       SDA_IN,
  output reg        SDA_OUT,
  output reg        SDA_OE_OUT,
  // Straps and protection
  input  wire       SELECT_STRAP_BIT0_IN,
  input  wire       SELECT_STRAP_BIT1_IN,
  input  wire       SELECT_STRAP_BIT2_IN,
  input  wire       WP_IN,
  // Status
  output reg        BUSY_OUT
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_HDR  = 3'h1;
  localparam [2:0] ST_ADDR = 3'h2;
  localparam [2:0] ST_WDAT = 3'h3;
  localparam [2:0] ST_RDAT = 3'h4;
  localparam [2:0] ST_RACK = 3'h5;
  localparam [2:0] ST_IGN  = 3'h6;
  // IGN waits for the next START or STOP; IDLE likewise, but is the home state

  ////////////////////////////////////////////////////////////////////////////
  reg        rst_m;
  reg        rst_n;
  always @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // Two-stage synchronisers, one per pin; stage one is read only by stage two
  wire [5:0] pin_raw = {WP_IN, SELECT_STRAP_BIT2_IN, SELECT_STRAP_BIT1_IN,
                        SELECT_STRAP_BIT0_IN, SDA_IN, SCL_IN};
  wire [5:0] sync_b;
  reg        scl_d;
  reg        sda_d;
  genvar     g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
      reg stage_a;
      reg stage_b;
      // Idle-high reset so no false edge or condition follows release
      always @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
          stage_a <= 1'b1;
          stage_b <= 1'b1;
        end else begin
          stage_a <= pin_raw[g];
          stage_b <= stage_a;
        end
      end
      assign sync_b[g] = stage_b;
    end
  endgenerate

  // Delayed copies for edge and condition detection
  always @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= sync_b[0];
      sda_d <= sync_b[1];
    end
  end

  wire       scl    = sync_b[0];
  wire       sda    = sync_b[1];
  // Undriven straps reach here as X in simulation; board pulls make them low
  wire [2:0] strap  = (HAS_STRAPS != 0) ? (sync_b[4:2] & 3'h7) : 3'h0;
  wire       wp     = sync_b[5];
  wire       scl_rise = scl & ~scl_d;
  wire       scl_fall = ~scl & scl_d;
  wire       start_c  = scl & scl_d & sda_d & ~sda;
  wire       stop_c   = scl & scl_d & ~sda_d & sda;

  ////////////////////////////////////////////////////////////////////////////
  reg  [7:0]               mem [0:`SEEP_MEM_BYTES-1];
  reg  [7:0]               page_buf [0:`SEEP_PAGE_BYTES-1];
  reg  [`SEEP_PAGE_BYTES-1:0] page_vld;
  integer                  i;
  initial begin
    for (i = 0; i < `SEEP_MEM_BYTES; i = i + 1)
      mem[i] = `SEEP_ERASED;
  end

  reg  [2:0]               state;
  reg  [3:0]               bitcnt;
  reg  [7:0]               shreg;
  reg  [`SEEP_ADDR_W-1:0]  addr;
  reg                      addr_hi;
  reg                      wr_ok;
  reg                      wr_any;
  reg                      ack_phase;
  reg                      master_ack;
  reg  [31:0]              prog_cnt;
  reg  [`SEEP_OFS_W:0]     commit_idx;
  reg                      committing;
  reg                      wp_snap;
  wire [7:0]               rx_byte = {shreg[6:0], sda};
  // Header is judged after the eighth capture, so the shift register holds it
  wire                     hdr_match = (shreg[7:4] == `SEEP_DEV_CODE) &&
                                       (shreg[3:1] == strap);
  wire [`SEEP_ADDR_W-1:0]  commit_addr = {addr[`SEEP_ADDR_W-1:`SEEP_OFS_W],
                                          commit_idx[`SEEP_OFS_W-1:0]};
  wire [`SEEP_OFS_W-1:0]   commit_ofs  = commit_idx[`SEEP_OFS_W-1:0];

  // Byte under the read pointer and the one after it
  wire [`SEEP_ADDR_W-1:0]  next_addr   = addr + 1'b1;
  wire [7:0]               cur_byte    = mem[addr];
  wire [7:0]               next_byte   = mem[next_addr];

  // Byte boundary as the bus engine sees it, with the same priorities
  wire                     bus_live    = !BUSY_OUT && !stop_c && !start_c &&
                                         (state != ST_IDLE) && (state != ST_IGN);
  wire                     byte_end    = bus_live && scl_fall && !ack_phase &&
                                         (bitcnt == 4'h8);

  // Protection is judged once, before the first data byte is taken
  wire                     wr_accept   = wr_ok && !(wp_snap && !wr_any);
  wire                     page_we     = byte_end && (state == ST_WDAT) && wr_accept;
  wire                     commit_we   = BUSY_OUT && committing && page_vld[commit_ofs];

  // Busy never ends before the page copy is complete, even for short timers
  wire                     prog_done   = !committing && (prog_cnt >= PROG_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Arrays sit outside the reset process so they can map to plain memory
  always @(posedge SYS_CLK_IN) begin
    if (page_we) begin
      page_buf[addr[`SEEP_OFS_W-1:0]] <= shreg;
    end
  end

  always @(posedge SYS_CLK_IN) begin
    if (commit_we) begin
      mem[commit_addr] <= page_buf[commit_ofs];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming timer; held at zero while idle so each launch starts fresh
  always @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      prog_cnt <= 32'h0;
    end else if (!BUSY_OUT) begin
      prog_cnt <= 32'h0;
    end else begin
      prog_cnt <= prog_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine: header, then address and write data, or read data.
  // STOP and START are checked first so they can cut any transfer.
  // While busy the bus is ignored and nothing is acknowledged.

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      addr       <= {`SEEP_ADDR_W{1'b0}};
      addr_hi    <= 1'b0;
      wr_ok      <= 1'b0;
      wr_any     <= 1'b0;
      ack_phase  <= 1'b0;
      master_ack <= 1'b0;
      commit_idx <= {(`SEEP_OFS_W+1){1'b0}};
      committing <= 1'b0;
      wp_snap    <= 1'b0;
      page_vld   <= {`SEEP_PAGE_BYTES{1'b0}};
      SDA_OUT    <= 1'b0;
      SDA_OE_OUT <= 1'b0;
      BUSY_OUT   <= 1'b0;
    end else if (BUSY_OUT) begin
      // Programming: bus ignored, SDA released
      SDA_OE_OUT <= 1'b0;
      state      <= ST_IDLE;
      if (committing) begin
        commit_idx <= commit_idx + 1'b1;
        if (commit_idx == `SEEP_PAGE_BYTES - 1)
          committing <= 1'b0;
      end
      if (prog_done) begin
        BUSY_OUT <= 1'b0;
        page_vld <= {`SEEP_PAGE_BYTES{1'b0}};
      end
    end else if (stop_c) begin
      SDA_OE_OUT <= 1'b0;
      state      <= ST_IDLE;
      if (wr_any) begin
        BUSY_OUT   <= 1'b1;
        committing <= 1'b1;
        commit_idx <= {(`SEEP_OFS_W+1){1'b0}};
      end
      wr_any <= 1'b0;
    end else if (start_c) begin
      SDA_OE_OUT <= 1'b0;
      state      <= ST_HDR;
      bitcnt     <= 4'h0;
      ack_phase  <= 1'b0;
      // Unfinished write session is dropped on repeated START
      wr_any     <= 1'b0;
      page_vld   <= {`SEEP_PAGE_BYTES{1'b0}};
    end else if (state != ST_IDLE && state != ST_IGN) begin
      if (scl_rise) begin
        if (ack_phase) begin
          master_ack <= ~sda;
        end else begin
          shreg  <= rx_byte;
          bitcnt <= bitcnt + 4'h1;
        end
      end
      if (scl_fall) begin
        if (ack_phase) begin
          // End of ninth clock
          ack_phase <= 1'b0;
          bitcnt    <= 4'h0;
          if (state == ST_RACK) begin
            if (master_ack) begin
              state      <= ST_RDAT;
              SDA_OUT    <= 1'b0;
              SDA_OE_OUT <= ~next_byte[7];
            end else begin
              state      <= ST_IGN;
              SDA_OE_OUT <= 1'b0;
            end
            // Pointer moves past every byte sent, acknowledged or not
            addr <= next_addr;
          end else if (state == ST_RDAT) begin
            SDA_OE_OUT <= ~cur_byte[7];
            SDA_OUT    <= 1'b0;
          end else begin
            SDA_OE_OUT <= 1'b0;
            if (state == ST_WDAT)
              wp_snap <= wp;
          end
        end else if (bitcnt == 4'h8) begin
          // Ninth clock: answer or release
          ack_phase <= 1'b1;
          SDA_OUT   <= 1'b0;
          SDA_OE_OUT <= 1'b0;
          case (state)
            ST_HDR: begin
              if (hdr_match) begin
                SDA_OE_OUT <= 1'b1;
                state      <= shreg[0] ? ST_RDAT : ST_ADDR;
                addr_hi    <= 1'b1;
              end else begin
                state <= ST_IGN;
              end
            end
            ST_ADDR: begin
              SDA_OE_OUT <= 1'b1;
              if (addr_hi) begin
                addr    <= {shreg[3:0], addr[7:0]};
                addr_hi <= 1'b0;
              end else begin
                addr  <= {addr[11:8], shreg};
                state <= ST_WDAT;
                wr_ok <= 1'b1;
              end
            end
            ST_WDAT: begin
              if (wp_snap && !wr_any)
                wr_ok <= 1'b0;
              if (wr_accept) begin
                SDA_OE_OUT <= 1'b1;
                page_vld[addr[`SEEP_OFS_W-1:0]] <= 1'b1;
                wr_any <= 1'b1;
                addr <= {addr[`SEEP_ADDR_W-1:`SEEP_OFS_W],
                         addr[`SEEP_OFS_W-1:0] + 1'b1};
              end else begin
                state <= ST_IGN;
              end
            end
            ST_RDAT: begin
              state <= ST_RACK;
            end
            default: begin
              state <= ST_IGN;
            end
          endcase
        end else if (state == ST_RDAT || state == ST_RACK) begin
          // Shift next data bit, driven only as a low
          SDA_OUT    <= 1'b0;
          SDA_OE_OUT <= (state == ST_RDAT) ? ~cur_byte[3'h7 - bitcnt[2:0]] : 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test/seep_target_props.sv */
// Port assertions for the serial memory target
`timescale 1ns/1ps
`default_nettype none
module seep_target_props #(
  parameter integer PROG_CYCLES = 200
) (
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT,
  input wire logic WP_IN,
  input wire logic BUSY_OUT
);
  logic seen;
  int   cnt;
  always @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      seen <= 1'b0;
      cnt  <= 0;
    end else begin
      if (SCL_IN && $fell(SDA_IN)) seen <= 1'b1;
      cnt <= BUSY_OUT ? cnt + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  sequence s_idle;
    SCL_IN && SDA_IN;
  endsequence
  a_drive_low: assert property (SDA_OE_OUT |-> !SDA_OUT)
    else $error("sda driven high");
  a_busy_quiet: assert property (BUSY_OUT |-> !SDA_OE_OUT)
    else $error("ack while busy");
  a_oe_scl_high: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_OUT))
    else $error("sda moved while scl high");
  a_quiet_start: assert property (!seen |-> !SDA_OE_OUT)
    else $error("answer before start");
  a_busy_len: assert property ($fell(BUSY_OUT) |-> cnt == PROG_CYCLES)
    else $error("program time wrong");
  a_busy_max: assert property (cnt <= PROG_CYCLES)
    else $error("program time too long");
  a_busy_idle: assert property ($rose(BUSY_OUT) |-> s_idle)
    else $error("program not after stop");
  a_wp_blocks: assert property ($rose(BUSY_OUT) |-> !$past(WP_IN, 4))
    else $error("program under protect");
endmodule
bind seep_target seep_target_props #(.PROG_CYCLES(PROG_CYCLES)) seep_target_props_i (
  .SYS_CLK_IN(SYS_CLK_IN), .RSTN_IN(RSTN_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .WP_IN(WP_IN), .BUSY_OUT(BUSY_OUT));
`default_nettype wire

/* test/seep_ctl.sv */
// Two-wire bus controller model
`timescale 1ns/1ps
`default_nettype none
module seep_ctl (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_oe_out
);
  // Clock stands high between frames
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic q();
    repeat (2) @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic start();
    sda_oe_out <= 1'b0;
    q();
    scl_out <= 1'b1;
    q();
    sda_oe_out <= 1'b1;
    q();
    scl_out <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_oe_out <= 1'b1;
    q();
    scl_out <= 1'b1;
    q();
    sda_oe_out <= 1'b0;
    q();
  endtask
  // Data moves only in the low half
  task automatic bit_io(input logic b, output logic r);
    sda_oe_out <= !b;
    q();
    scl_out <= 1'b1;
    q();
    r = sda_in;
    q();
    scl_out <= 1'b0;
    q();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!more, r);
  endtask
endmodule
`default_nettype wire

/* test/tb_seep_target.sv */
// Self-checking bench for the serial memory target
`timescale 1ns/1ps
`default_nettype none
module tb_seep_target;
  localparam int         PROG  = 200;
  localparam logic [2:0] STRAP = 3'h5;
  logic      clk   = 1'b0;
  logic      rstn  = 1'b0;
  logic      wp    = 1'b0;
  logic      scl;
  logic      m_oe;
  logic      oe;
  logic      so;
  logic      busy;
  wire logic sda   = (oe ? so : 1'b1) & !m_oe;
  int        fails = 0;
  int        total_checks = 0;
  seep_target #(.PROG_CYCLES(PROG), .HAS_STRAPS(1)) seep_target_i (
    .SYS_CLK_IN(clk), .RSTN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(so),
    .SDA_OE_OUT(oe), .SELECT_STRAP_BIT0_IN(STRAP[0]), .SELECT_STRAP_BIT1_IN(STRAP[1]),
    .SELECT_STRAP_BIT2_IN(STRAP[2]), .WP_IN(wp), .BUSY_OUT(busy));
  seep_ctl seep_ctl_i (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic hdr(input logic [2:0] s, input logic rw, output logic ack);
    seep_ctl_i.start();
    seep_ctl_i.wr_byte({4'hA, s, rw}, ack);
  endtask
  task automatic set_addr(input logic [15:0] a);
    logic ack;
    hdr(STRAP, 1'b0, ack);
    chk(ack, 1'b1);
    seep_ctl_i.wr_byte(a[15:8], ack);
    chk(ack, 1'b1);
    seep_ctl_i.wr_byte(a[7:0], ack);
    chk(ack, 1'b1);
  endtask
  task automatic rd2(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic       ack;
    logic [7:0] d;
    set_addr(a);
    hdr(STRAP, 1'b1, ack);
    chk(ack, 1'b1);
    seep_ctl_i.rd_byte(1'b1, d);
    chk(d, e0);
    seep_ctl_i.rd_byte(1'b0, d);
    chk(d, e1);
    seep_ctl_i.stop();
  endtask
  task automatic t_select();
    logic ack;
    hdr(3'h2, 1'b0, ack);
    chk(ack, 1'b0);
    seep_ctl_i.stop();
  endtask
  // Two bytes past a page wrap over the first two
  task automatic t_page();
    logic ack;
    int   n;
    set_addr(16'hF01E);
    for (int k = 0; k < 34; k++) begin
      seep_ctl_i.wr_byte(8'h40 + k[7:0], ack);
      chk(ack, 1'b1);
    end
    seep_ctl_i.stop();
    repeat (2) @(posedge clk);
    chk({7'h00, busy}, 8'h01);
    hdr(STRAP, 1'b0, ack);
    chk(ack, 1'b0);
    n = 0;
    while (ack !== 1'b1 && n < 50) begin
      seep_ctl_i.stop();
      hdr(STRAP, 1'b0, ack);
      n++;
    end
    seep_ctl_i.stop();
    chk(ack, 1'b1);
    chk({7'h00, busy}, 8'h00);
  endtask
  task automatic t_read();
    logic       ack;
    logic [7:0] d;
    rd2(16'hF01E, 8'h60, 8'h61);
    rd2(16'h0FFF, 8'hFF, 8'h42);
    hdr(STRAP, 1'b1, ack);
    chk(ack, 1'b1);
    seep_ctl_i.rd_byte(1'b0, d);
    seep_ctl_i.stop();
    chk(d, 8'h43);
  endtask
  task automatic t_protect();
    logic ack;
    wp <= 1'b1;
    set_addr(16'h0000);
    seep_ctl_i.wr_byte(8'h55, ack);
    chk(ack, 1'b0);
    seep_ctl_i.stop();
    rd2(16'h0000, 8'h42, 8'h43);
    wp <= 1'b0;
  endtask
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    t_select();
    t_page();
    t_read();
    t_protect();
    finish_test();
  end
  initial begin
    #2000000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
